// >>> tb_timed_io_port_with_pin_sharing.sv
// Self-checking bench for the timed I/O port block.
// Assumes a 50 MHz clock and the pin model on the far side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_timed_io_port_with_pin_sharing;
   import tiop_pkg::*;
   typedef struct packed {
      logic [9:0] a;
      logic [31:0] w;
      logic [31:0] e;
   } tiop_row_t;
   tiop_row_t rows [8] = '{
      '{10'h020, 32'h0000_0116, 32'h0000_0116}, '{10'h028, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
      '{10'h06C, 32'hABCD_1234, 32'h0000_1234}, '{10'h050, 32'h0000_1234, 32'h0000_0000},
      '{10'h094, 32'h0000_FFFF, 32'h0000_0000}, '{10'h108, 32'h0000_01A5, 32'h0000_00A5},
      '{10'h0A0, 32'hFFFF_FFFF, 32'h0000_0000}, '{10'h088, 32'h8765_4321, 32'h8765_4321}};
   logic CLK;
   logic RST_B;
   logic [9:0] ADDR;
   logic [31:0] WDATA;
   logic WR;
   logic RD;
   logic [31:0] RDATA;
   logic [NPIN-1:0] PIN_I;
   logic [NPIN-1:0] PIN_O;
   logic [NPIN-1:0] PIN_OE;
   logic [NPORT-1:0] EVENT;
   logic [NPIN-1:0] ext_val;
   logic [NPIN-1:0] ext_oe;
   logic [31:0] d;
   logic [31:0] c;
   int n;
   int mismatches = 0;
   int checked = 0;
   tiop_port u_dut (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
      .RDATA(RDATA), .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .EVENT(EVENT));
   tiop_pins_model u_pins (.pin_o(PIN_O), .pin_oe(PIN_OE), .ext_val(ext_val), .ext_oe(ext_oe), .pin_i(PIN_I));
   task automatic wr(input logic [9:0] a, input logic [31:0] v);
      @(posedge CLK);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [9:0] a, output logic [31:0] v);
      @(posedge CLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      @(posedge CLK);
      v = RDATA;
   endtask : rd
   task automatic wait_ev(input int p, output int k);
      k = 0;
      do begin
         @(posedge CLK);
         k++;
      end while (EVENT[p] !== 1'b1 && k < 200);
      `CHK("event", 1'b1, EVENT[p])
      @(posedge CLK);
   endtask : wait_ev
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict
   initial begin
      CLK = 1'b0;
      forever #10 CLK = ~CLK;
   end
   initial begin
      #(20 * 20000);
      mismatches++;
      give_verdict();
   end
   initial begin
      RST_B = 1'b0;
      ADDR = '0;
      WDATA = '0;
      WR = 1'b0;
      RD = 1'b0;
      ext_val = '0;
      ext_oe = '0;
      repeat (16) @(posedge CLK);
      RST_B <= 1'b1;
      `CHK("oe_rst", 32'h0000_0000, PIN_OE)
      rd(10'h000, d);
      `CHK("ctrl_rst", 32'(CTRL_RST), d)
      rd(10'h004, d);
      `CHK("data_rst", DATA_RST, d)
      foreach (rows[i]) begin
         wr(rows[i].a, rows[i].w);
         rd(rows[i].a, d);
         `CHK("row", rows[i].e, d)
      end
      wr(10'h000, 32'h0000_0007);
      wr(10'h004, 32'hAAAA_AAAA);
      wait_ev(0, n);
      `CHK("od_drive", 2'b10, {PIN_OE[0], PIN_O[0]})
      @(posedge CLK);
      `CHK("od_float", 1'b0, PIN_OE[0])
      wr(10'h000, 32'h0000_0000);
      wr(10'h040, 32'h0000_0013);
      wr(10'h044, 32'h4433_2211);
      wait_ev(2, n);
      for (int k = 0; k < 4; k++) begin
         `CHK("slice", 8'(32'h4433_2211 >> (8 * k)), PIN_O[7:0])
         `CHK("oe8", 32'h0000_00FF, PIN_OE)
         @(posedge CLK);
      end
      wr(10'h040, 32'h0000_001B);
      rd(10'h050, c);
      rd(10'h050, d);
      `CHK("count", 32'(16'(c[15:0] + 16'd3)), d)
      wr(10'h04C, 32'(16'(c[15:0] + 16'd40)));
      wr(10'h044, 32'h0000_0055);
      wait_ev(2, n);
      `CHK("deferred", 1'b1, n >= 25)
      rd(10'h054, d);
      `CHK("stamp", 32'(16'(c[15:0] + 16'd40)), d)
      wr(10'h040, 32'h0000_0000);
      ext_oe <= 32'h0000_000F;
      wr(10'h028, 32'h0000_0005);
      wr(10'h020, 32'h0000_0081);
      repeat (20) @(posedge CLK);
      rd(10'h038, d);
      `CHK("held", 1'b0, d[STAT_FULL])
      `CHK("in_oe", 4'h0, PIN_OE[3:0])
      ext_val <= 32'h0000_0005;
      wait_ev(1, n);
      rd(10'h024, d);
      `CHK("captured", 32'h5555_5555, d)
      rd(10'h038, d);
      `CHK("drained", 1'b0, d[STAT_FULL])
      wr(10'h020, 32'h0000_0000);
      wr(OFF_LINK, 32'h0000_0001);
      wr(10'h000, 32'h0000_0001);
      wr(10'h080, 32'h0000_0003);
      wr(10'h084, 32'h1234_5678);
      wait_ev(4, n);
      `CHK("shared_oe", 32'hFFFF_FF0E, PIN_OE)
      `CHK("word", 32'h1234_5608, PIN_O & PIN_OE)
      wr(OFF_LINK, 32'h0000_0000);
      repeat (4) @(posedge CLK);
      `CHK("unlinked", 32'h0000_00F0, PIN_OE & 32'h0000_00F0)
      RST_B <= 1'b0;
      repeat (2) @(posedge CLK);
      `CHK("oe_midrst", 32'h0000_0000, PIN_OE)
      RST_B <= 1'b1;
      rd(10'h080, d);
      `CHK("ctrl_midrst", 32'(CTRL_RST), d)
      give_verdict();
   end
endmodule : tb_timed_io_port_with_pin_sharing
`default_nettype wire

// >>> tiop_clkblk.sv
// Programmable clock block: one-cycle tick every DIV+1 clocks.
// Assumes the divisor is static or changed between ticks.
`timescale 1ns/1ps
`default_nettype none
module tiop_clkblk
   import tiop_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] div,
   output logic tick
);
   logic [7:0] cnt_reg;
   logic [7:0] cnt_next;
   logic tick_reg;
   wire wrap = (cnt_reg >= div);

   assign cnt_next = wrap ? 8'h00 : cnt_reg + 8'h01;
   assign tick = tick_reg;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_reg <= 8'h00;
         tick_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         tick_reg <= wrap;
      end
   end
endmodule : tiop_clkblk
`default_nettype wire

// >>> tiop_pins_model.sv
// External pin hardware: drives chosen pins, pull-ups elsewhere.
// Assumes the bench sets which pins it drives.
`timescale 1ns/1ps
`default_nettype none
module tiop_pins_model
   import tiop_pkg::*;
(
   input wire logic [NPIN-1:0] pin_o,
   input wire logic [NPIN-1:0] pin_oe,
   input wire logic [NPIN-1:0] ext_val,
   input wire logic [NPIN-1:0] ext_oe,
   output logic [NPIN-1:0] pin_i
);
   // Released lines float to the pull-up level
   assign pin_i = (pin_oe & pin_o) | (~pin_oe & ext_oe & ext_val) | (~pin_oe & ~ext_oe);
endmodule : tiop_pins_model
`default_nettype wire

// >>> tiop_pkg.sv
// Shared constants and types for the timed I/O port block.
// Assumes one 50 MHz clock and a simple strobe register port.
package tiop_pkg;
   localparam int NPORT = 5;
   localparam int NPIN = 32;
   localparam int NCLKB = 6;
   localparam int CNT_W = 16;
   localparam int CLK_MHZ = 50;
   localparam int REF_MHZ = 100;
   // Reference block divisor: fastest rate one clock allows
   localparam int REF_DIV_DEF = (CLK_MHZ >= REF_MHZ) ? (CLK_MHZ / REF_MHZ) - 1 : 0;
   // Per-port register offsets, port stride 0x20
   localparam logic [9:0] PORT_STRIDE = 10'h020;
   localparam logic [4:0] OFF_CTRL = 5'h00;
   localparam logic [4:0] OFF_DATA = 5'h04;
   localparam logic [4:0] OFF_COND = 5'h08;
   localparam logic [4:0] OFF_TIME = 5'h0C;
   localparam logic [4:0] OFF_COUNT = 5'h10;
   localparam logic [4:0] OFF_STAMP = 5'h14;
   localparam logic [4:0] OFF_STAT = 5'h18;
   // Global registers
   localparam logic [9:0] OFF_LINK = 10'h100;
   localparam logic [9:0] OFF_CLKDIV = 10'h100;
   localparam logic [9:0] OFF_CLKDIV_END = 10'h114;
   // Status fields
   localparam int STAT_FULL = 0;
   localparam int STAT_BUSY = 1;
   // Reset values
   localparam logic [31:0] DATA_RST = 32'h0000_0000;
   localparam logic [7:0] CLKDIV_RST = 8'h00;
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
   localparam logic [31:0] LINK_PINS_DEF = 32'h0000_00F0;

   typedef enum logic [1:0] {
      TIOP_COND_NONE,
      TIOP_COND_EQ,
      TIOP_COND_NE
   } tiop_cond_t;

   typedef struct packed {
      logic [1:0] cond;
      logic [2:0] clk_sel;
      logic timed;
      logic od;
      logic out;
      logic en;
   } tiop_ctrl_t;

   localparam tiop_ctrl_t CTRL_RST = '0;
   localparam int CTRL_W = $bits(tiop_ctrl_t);

   typedef enum logic {
      ST_IDLE,
      ST_SHIFT
   } tiop_state_t;

   // Port widths 1, 4, 8, 16, 32 by index
   function automatic int tiop_width(input int p);
      return (p == 0) ? 1 : (4 << (p - 1));
   endfunction : tiop_width
endpackage : tiop_pkg

// >>> tiop_port.sv
// Timed I/O port block: five ports sharing 32 pins, six clock blocks.
// Assumes a strobe register port and pins from outside the clock domain.
// Behaviour
// RL1 - Ports of widths 1, 4, 8, 16 and 32 pins over the pins.
// RL2 - A port's pins all share one direction.
// RL3 - Ports drive pins or sample them, optionally waiting for a condition.
// RL4 - Every register access completes in one cycle without wait.
// RL5 - Open-drain option per port: zero pulls low, one leaves undriven.
// RL6 - Data passes through a serializer and a transfer register.
// RL7 - Each port has a 16-bit counter timing transfers.
// RL8 - Counter readable anytime; transfers can wait for a given count.
// RL9 - Counter value captured as timestamp for each transfer.
// RL10 - Enabled link disables the port function on its pins.
// RL11 - Enabled narrower port wins over wider ports on shared pins.
// RL12 - Unshared pins of a wider port stay usable.
// RL13 - Every port keeps its own width regardless of sharing.
// RL14 - Six clock blocks set port rates; blocks one to five are programmable.
// RL15 - Block zero gives the reference clock; others are settable.
// RL16 - Pin events go straight to the scheduler as event pulses.
// RL17 - Counter steps once per port clock edge and wraps.
// RL18 - Timed transfer at counter match; timestamp equals that value. Inputs under 32 pins stamp at their last slice, NS-1 counts later.
`timescale 1ns/1ps
`default_nettype none
module tiop_port
   import tiop_pkg::*;
#(
   parameter int REF_DIV = REF_DIV_DEF,
   parameter logic [31:0] LINK_PINS = LINK_PINS_DEF
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [9:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [31:0] RDATA,
   input wire logic [NPIN-1:0] PIN_I,
   output logic [NPIN-1:0] PIN_O,
   output logic [NPIN-1:0] PIN_OE,
   output logic [NPORT-1:0] EVENT
);
   if (REF_DIV < 0 || REF_DIV > 255) begin : g_chk
      $error("REF_DIV out of range");
   end
   if (NCLKB > 8) begin : g_cbchk
      $error("too many clock blocks for the tick vector");
   end

   // Pin synchroniser
   logic [NPIN-1:0] pin_m_reg;
   logic [NPIN-1:0] pin_s_reg;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         pin_m_reg <= '0;
         pin_s_reg <= '0;
      end else begin
         pin_m_reg <= PIN_I;
         pin_s_reg <= pin_m_reg;
      end
   end

   // Address decode
   wire [2:0] pidx = ADDR[7:5];
   wire [4:0] off = ADDR[4:0];
   wire port_hit = (ADDR[9:8] == 2'b00) && (pidx < 3'(NPORT));
   wire link_hit = (ADDR == OFF_LINK);
   wire div_hit = (ADDR > OFF_CLKDIV) && (ADDR <= OFF_CLKDIV_END) && (ADDR[1:0] == 2'b00);
   wire [2:0] div_idx = 3'((ADDR - OFF_CLKDIV) >> 2);

   // Link enable and clock block divisors
   logic link_reg;
   logic [7:0] div_reg [NCLKB];
   logic [7:0] cb_div [NCLKB];
   logic [7:0] cb_tick;
   wire [NPIN-1:0] link_pin = link_reg ? LINK_PINS : '0;

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         link_reg <= 1'b0;
      end else if (WR && link_hit) begin
         link_reg <= WDATA[0];
      end
   end

   assign cb_tick[7:6] = 2'b00;
   for (genvar k = 0; k < NCLKB; k++) begin : g_cb
      if (k == 0) begin : g_ref
         assign div_reg[k] = 8'(REF_DIV); // RL15
      end else begin : g_prog
         logic [7:0] d_reg;
         always_ff @(posedge CLK or negedge RST_B) begin
            if (!RST_B) begin
               d_reg <= CLKDIV_RST;
            end else if (WR && div_hit && div_idx == 3'(k)) begin
               d_reg <= WDATA[7:0]; // RL15
            end
         end
         assign div_reg[k] = d_reg;
      end
      assign cb_div[k] = div_reg[k];
      tiop_clkblk u_cb (
         .clk(CLK),
         .rst_b(RST_B),
         .div(cb_div[k]),
         .tick(cb_tick[k]) // RL14
      );
   end

   // Per-port state exported for pin muxing and readback
   logic [NPORT-1:0] en_v;
   logic [NPORT-1:0] out_v;
   logic [NPORT-1:0] od_v;
   logic [NPIN-1:0] pv_a [NPORT];
   logic [NPIN-1:0] own_t [NPORT];
   logic [31:0] prd [NPORT];
   logic [NPORT-1:0] ev_v;

   // Pin ownership: link first, then narrowest enabled port
   logic [NPORT-1:0] own [NPIN];
   logic [NPIN-1:0] o_next;
   logic [NPIN-1:0] oe_next;
   for (genvar i = 0; i < NPIN; i++) begin : g_pin
      logic [NPORT-1:0] cov;
      logic [NPORT-1:0] cand;
      logic [NPORT-1:0] pvb;
      for (genvar q = 0; q < NPORT; q++) begin : g_cov
         assign cov[q] = (i < tiop_width(q));
         assign own_t[q][i] = own[i][q];
         assign pvb[q] = pv_a[q][i];
      end
      assign cand = en_v & cov;
      assign own[i] = link_pin[i] ? '0 : (cand & (~cand + 5'h01)); // RL10 RL11 RL12
      wire [NPORT-1:0] drv = own[i] & out_v;
      wire [NPORT-1:0] hi = drv & ~od_v & pvb;
      wire [NPORT-1:0] lo_od = drv & od_v & ~pvb;
      assign o_next[i] = |hi;
      assign oe_next[i] = |(drv & ~od_v) | (|lo_od); // RL5
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         PIN_O <= '0;
         PIN_OE <= '0;
      end else begin
         PIN_O <= o_next;
         PIN_OE <= oe_next;
      end
   end

   // Ports
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      localparam int W = tiop_width(p); // RL1
      localparam int NS = NPIN / W;
      localparam logic [5:0] NS_M1 = 6'(NS - 1);
      localparam logic [31:0] MSK = 32'hFFFF_FFFF >> (NPIN - W);
      if ((NPIN % W) != 0 || NS > 63) begin : g_wchk
         $error("port width does not fit the pins");
      end

      tiop_ctrl_t ctrl_reg;
      tiop_state_t st_reg;
      tiop_state_t st_next;
      logic [31:0] tr_reg;
      logic [31:0] sh_reg;
      logic [31:0] sh_next;
      logic [31:0] pv_reg;
      logic [31:0] cond_reg;
      logic [CNT_W-1:0] time_reg;
      logic [CNT_W-1:0] cnt_reg;
      logic [CNT_W-1:0] stamp_reg;
      logic [5:0] sl_reg;
      logic [5:0] sl_next;
      logic full_reg;
      logic ev_reg;
      logic [31:0] stat_w;

      wire sel = port_hit && (pidx == 3'(p));
      wire wr_ctrl = WR && sel && (off == OFF_CTRL);
      wire wr_data = WR && sel && (off == OFF_DATA) && ctrl_reg.out;
      wire rd_data = RD && sel && (off == OFF_DATA) && !ctrl_reg.out;
      wire tick = cb_tick[ctrl_reg.clk_sel];
      wire run = ctrl_reg.en && tick;
      wire t_ok = !ctrl_reg.timed || (cnt_reg == time_reg); // RL8 RL18
      wire [31:0] pin_in = pin_s_reg & MSK & own_t[p]; // RL13
      wire [31:0] cond_m = cond_reg & MSK;
      wire c_eq = (pin_in == cond_m);
      wire c_ok = (ctrl_reg.cond == TIOP_COND_EQ) ? c_eq :
                  (ctrl_reg.cond == TIOP_COND_NE) ? !c_eq : 1'b1; // RL3
      wire [31:0] sh_in = (sh_reg >> W) | (pin_in << (NPIN - W));
      wire idle = (st_reg == ST_IDLE);
      wire step = run && (st_reg == ST_SHIFT);
      wire last = (sl_reg == 6'h01);
      wire load_out = run && ctrl_reg.out && idle && full_reg && t_ok;
      wire start_in = run && !ctrl_reg.out && idle && !full_reg && t_ok && c_ok;
      wire done_in = (start_in && NS == 1) || (step && !ctrl_reg.out && last);

      // Serializer sequencing
      always_comb begin
         st_next = st_reg;
         sl_next = sl_reg;
         case (st_reg)
            ST_IDLE: begin
               if (load_out || start_in) begin
                  sl_next = NS_M1;
                  if (NS > 1) begin
                     st_next = ST_SHIFT;
                  end
               end
            end
            ST_SHIFT: begin
               if (step) begin
                  sl_next = sl_reg - 6'h01;
                  if (last) begin
                     st_next = ST_IDLE;
                  end
               end
            end
            default: begin
               st_next = ST_IDLE;
            end
         endcase
         if (wr_ctrl) begin
            st_next = ST_IDLE;
         end
      end
      assign sh_next = load_out ? (tr_reg >> W) :
                       (start_in || (step && !ctrl_reg.out)) ? sh_in :
                       step ? (sh_reg >> W) : sh_reg;

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            ctrl_reg <= CTRL_RST;
            cond_reg <= DATA_RST;
            time_reg <= CNT_RST;
         end else if (WR && sel) begin
            if (off == OFF_CTRL) begin
               ctrl_reg <= tiop_ctrl_t'(WDATA[CTRL_W-1:0]); // RL2 RL5
            end
            if (off == OFF_COND) begin
               cond_reg <= WDATA;
            end
            if (off == OFF_TIME) begin
               time_reg <= WDATA[CNT_W-1:0]; // RL8
            end
         end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            st_reg <= ST_IDLE;
            sl_reg <= 6'h00;
            sh_reg <= DATA_RST;
         end else begin
            st_reg <= st_next;
            sl_reg <= sl_next;
            sh_reg <= sh_next; // RL6
         end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            cnt_reg <= CNT_RST;
         end else if (run) begin
            cnt_reg <= cnt_reg + 16'h0001; // RL7 RL17
         end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            pv_reg <= DATA_RST;
         end else if (load_out) begin
            pv_reg <= tr_reg & MSK;
         end else if (step && ctrl_reg.out) begin
            pv_reg <= sh_reg & MSK;
         end
      end

      // Transfer register; CTRL write clear beats hardware set, which beats read clear
      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            tr_reg <= DATA_RST;
            full_reg <= 1'b0;
         end else if (wr_ctrl) begin
            full_reg <= 1'b0;
         end else if (wr_data) begin
            tr_reg <= WDATA;
            full_reg <= 1'b1;
         end else if (done_in) begin
            tr_reg <= sh_in; // RL6
            full_reg <= 1'b1;
         end else if (load_out || rd_data) begin
            full_reg <= 1'b0;
         end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            stamp_reg <= CNT_RST;
            ev_reg <= 1'b0;
         end else begin
            if (load_out || done_in) begin
               stamp_reg <= cnt_reg; // RL9 RL18
            end
            ev_reg <= load_out || done_in; // RL16
         end
      end

      // Status word
      always_comb begin
         stat_w = 32'h0000_0000;
         stat_w[STAT_FULL] = full_reg;
         stat_w[STAT_BUSY] = !idle;
      end

      assign en_v[p] = ctrl_reg.en;
      assign out_v[p] = ctrl_reg.out;
      assign od_v[p] = ctrl_reg.od;
      assign pv_a[p] = pv_reg;
      assign ev_v[p] = ev_reg;
      assign prd[p] = (off == OFF_CTRL) ? 32'(ctrl_reg) :
                      (off == OFF_DATA) ? tr_reg :
                      (off == OFF_COND) ? cond_reg :
                      (off == OFF_TIME) ? 32'(time_reg) :
                      (off == OFF_COUNT) ? 32'(cnt_reg) : // RL8
                      (off == OFF_STAMP) ? 32'(stamp_reg) :
                      (off == OFF_STAT) ? stat_w : 32'h0000_0000;
   end

   assign EVENT = ev_v;

   // Read answer, one cycle after the strobe
   wire [31:0] rd_next = port_hit ? prd[pidx] :
                         link_hit ? 32'(link_reg) :
                         div_hit ? 32'(div_reg[div_idx]) : 32'h0000_0000;
   logic [31:0] rdata_reg;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= RD ? rd_next : 32'h0000_0000; // RL4
      end
   end
   assign RDATA = rdata_reg;
endmodule : tiop_port
`default_nettype wire

// >>> tiop_port_chk.sv
// Concurrent checks on the timed I/O port block's ports.
// Assumes CTRL and LINK writes on the bus are mirrored here.
`timescale 1ns/1ps
`default_nettype none
module tiop_port_chk
   import tiop_pkg::*;
#(
   parameter logic [31:0] LINK_PINS = LINK_PINS_DEF
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [9:0] ADDR,
   input wire logic [31:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [31:0] RDATA,
   input wire logic [NPIN-1:0] PIN_I,
   input wire logic [NPIN-1:0] PIN_O,
   input wire logic [NPIN-1:0] PIN_OE,
   input wire logic [NPORT-1:0] EVENT
);
   logic [4:0] en_reg;
   logic [4:0] out_reg;
   logic od0_reg;
   logic link_reg;
   logic [1:0] quiet_reg;
   wire ctrl_wr = WR && ADDR[9:8] == 2'b00 && ADDR[7:5] < 3'd5 && ADDR[4:0] == OFF_CTRL;
   wire settled = quiet_reg == 2'd3;
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         en_reg <= '0;
         out_reg <= '0;
         od0_reg <= 1'b0;
         link_reg <= 1'b0;
         quiet_reg <= 2'd0;
      end else begin
         quiet_reg <= WR ? 2'd0 : (settled ? quiet_reg : quiet_reg + 2'd1);
         if (ctrl_wr) begin
            en_reg[ADDR[7:5]] <= WDATA[0];
            out_reg[ADDR[7:5]] <= WDATA[1];
         end
         if (ctrl_wr && ADDR[7:5] == 3'd0) begin
            od0_reg <= WDATA[2];
         end
         if (WR && ADDR == OFF_LINK) begin
            link_reg <= WDATA[0];
         end
      end
   end
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);
   rd_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0000_0000)
      else $error("read data outside the read slot");
   link_pins_a: assert property (settled && link_reg |-> (PIN_OE & LINK_PINS) == '0)
      else $error("link pins still driven");
   in_dir_a: assert property (settled && en_reg[0] && !out_reg[0] |-> !PIN_OE[0])
      else $error("input port drives its pin");
   od_low_a: assert property (settled && en_reg[0] && out_reg[0] && od0_reg && PIN_OE[0] |-> !PIN_O[0])
      else $error("open drain drives high");
   hi_free_a: assert property (settled && !en_reg[4] |-> PIN_OE[31:16] == 16'h0000)
      else $error("upper pins driven without owner");
   mid_free_a: assert property (settled && en_reg[4:3] == 2'b00 |-> PIN_OE[15:8] == 8'h00)
      else $error("middle pins driven without owner");
   idle_pins_a: assert property (settled && en_reg == 5'b00000 |-> PIN_OE == '0)
      else $error("pins driven with all ports off");
   ev_owner_a: assert property (settled |-> (EVENT & ~en_reg) == 5'b00000)
      else $error("event from disabled port");
   ev_pulse_a: assert property (EVENT[1] |=> !EVENT[1])
      else $error("event longer than one cycle");
   cover property (EVENT[2]);
   cover property (EVENT[1]);
   cover property (link_reg && PIN_OE[31:8] != '0);
   cover property (od0_reg && en_reg[0] && PIN_OE[0]);
endmodule : tiop_port_chk
bind tiop_port tiop_port_chk #(.LINK_PINS(LINK_PINS)) u_chk (.CLK(CLK), .RST_B(RST_B), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE),
   .EVENT(EVENT));
`default_nettype wire
